// ===== src/mcudx_core.sv
// operand decode and execute core with register-file and stack ports
`timescale 1ns/1ps
`include "mcudx_defs.svh"

module mcudx_core
    import mcudx_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [8:0]  busAddr,
    input  wire logic [7:0]  busWrData,
    input  wire logic        busWrite,
    input  wire logic        busRead,
    output logic      [7:0]  busRdData_r,
    output logic      [15:0] progAddr_r,
    output logic             progRead_r,
    input  wire logic [7:0]  progData,
    output mcudx_stk_t       stkWr_r,
    output mcudx_wb_t        regWb_r
);
    mcudx_state_t state_r;
    mcudx_kind_t  kind;
    logic [7:0]  opc_r, b1_r, b2_r, aVal_r, ptrVal_r, effA_r, lo_r;
    logic [7:0]  flags_r, rp0_r, rp1_r, fl, bVal, res, ramRd, ramRaddr;
    logic [7:0]  aAddr, bAddr, ptrAddr, effA_c, effB_c, wrAddr, wrData, disp;
    logic [15:0] pc_r, sp_r, callT_r, w16;
    logic [8:0]  sum9;
    logic [4:0]  nib5;
    logic [1:0]  opndLeft_r;
    logic        run_r, irqEn_r, prVal_r, vecPh_r, halted, issue;
    logic        aInd, bInd, bImm, pair, wrEn, jump, cin, bitOp, coreWe;

    function automatic logic [7:0] wreg(input logic [3:0] r,
                                        input logic [7:0] p0,
                                        input logic [7:0] p1);
        wreg = r[3] ? {p1[7:3], r[2:0]} : {p0[7:3], r[2:0]};
    endfunction

    function automatic mcudx_kind_t opKind(input logic [7:0] o);
        case (o)
            `MCUDX_OP_DEC_R, `MCUDX_OP_DEC_IR: opKind = K_DEC;
            `MCUDX_OP_COUNT_DOWN_WORD_RR, `MCUDX_OP_COUNT_DOWN_WORD_IR: opKind = K_COUNT_DOWN_WORD;
            `MCUDX_OP_BAND, `MCUDX_OP_BOR, `MCUDX_OP_BIT_XOR_OP,
            `MCUDX_OP_BCMP: opKind = K_BIT;
            `MCUDX_OP_COMPARE_STEP_JUMP_EQUAL, `MCUDX_OP_COMPARE_STEP_JUMP_UNEQUAL: opKind = K_CPIJ;
            `MCUDX_OP_CALL_DA, `MCUDX_OP_CALL_RR,
            `MCUDX_OP_CALL_IA: opKind = K_CALL;
            default: begin
                if (o[3:0] == `MCUDX_NIB_LOOP_DOWN_BRANCH) begin
                    opKind = K_LOOP_DOWN_BRANCH;
                end else if (o[3:0] >= 4'h2 && o[3:0] <= 4'h7 &&
                             (o[7:4] == 4'h0 || o[7:4] == 4'h1 ||
                              o[7:4] == 4'h5 || o[7:4] == 4'hA)) begin
                    opKind = K_ALU;
                end else begin
                    opKind = K_NONE;
                end
            end
        endcase
    endfunction

    function automatic logic [1:0] opLen(input logic [7:0] o);
        case (opKind(o))
            K_DEC, K_COUNT_DOWN_WORD, K_LOOP_DOWN_BRANCH: opLen = 2'd1;
            K_BIT, K_CPIJ: opLen = 2'd2;
            K_CALL: opLen = (o == `MCUDX_OP_CALL_DA) ? 2'd2 : 2'd1;
            K_ALU: opLen = (o[3:0] < 4'h4) ? 2'd1 : 2'd2;
            default: opLen = 2'd0;
        endcase
    endfunction

    assign halted = (state_r == ST_HALT);
    assign kind = opKind(opc_r);

    // operand address decode
    always_comb begin
        aAddr = 8'h00;
        bAddr = 8'h00;
        ptrAddr = 8'h00;
        aInd = 1'b0;
        bInd = 1'b0;
        bImm = 1'b0;
        pair = (kind == K_COUNT_DOWN_WORD) || (kind == K_CALL);
        case (kind)
            K_ALU: begin
                case (opc_r[3:0])
                    4'h2: begin
                        aAddr = wreg(b1_r[7:4], rp0_r, rp1_r);
                        bAddr = wreg(b1_r[3:0], rp0_r, rp1_r);
                    end
                    4'h3: begin
                        aAddr = wreg(b1_r[7:4], rp0_r, rp1_r);
                        ptrAddr = wreg(b1_r[3:0], rp0_r, rp1_r);
                        bInd = 1'b1;
                    end
                    4'h4: begin
                        aAddr = b2_r;
                        bAddr = b1_r;
                    end
                    4'h5: begin
                        aAddr = b2_r;
                        ptrAddr = b1_r;
                        bInd = 1'b1;
                    end
                    4'h6: begin
                        aAddr = b1_r;
                        bImm = 1'b1;
                    end
                    default: begin
                        ptrAddr = b1_r;
                        aInd = 1'b1;
                        bImm = 1'b1;
                    end
                endcase
            end
            K_DEC, K_COUNT_DOWN_WORD: begin
                aAddr = b1_r;
                ptrAddr = b1_r;
                aInd = opc_r[0];
            end
            K_BIT: begin
                aAddr = wreg(b1_r[7:4], rp0_r, rp1_r);
                bAddr = b2_r;
            end
            K_CPIJ: begin
                aAddr = wreg(b1_r[3:0], rp0_r, rp1_r);
                ptrAddr = wreg(b1_r[7:4], rp0_r, rp1_r);
                bInd = 1'b1;
            end
            K_LOOP_DOWN_BRANCH: aAddr = wreg(opc_r[7:4], rp0_r, rp1_r);
            K_CALL: aAddr = b1_r;
            default: aAddr = 8'h00;
        endcase
    end

    // pairs forced onto an even register
    assign effA_c = (aInd ? ramRd : aAddr) & (pair ? 8'hFE : 8'hFF);
    assign effB_c = pair ? (effA_r | 8'h01) : (bInd ? ptrVal_r : bAddr);

    always_comb begin
        case (state_r)
            ST_PTR: ramRaddr = ptrAddr;
            ST_RDA: ramRaddr = effA_c;
            default: ramRaddr = effB_c;
        endcase
    end

    // execute: result, flags, one register write, branch
    always_comb begin
        bVal = bImm ? b2_r : ramRd;
        fl = flags_r;
        res = 8'h00;
        sum9 = 9'h000;
        nib5 = 5'h00;
        w16 = {aVal_r, ramRd} - 16'h0001;
        cin = opc_r[4] & flags_r[`MCUDX_F_C];
        bitOp = 1'b0;
        wrEn = 1'b0;
        wrAddr = effA_r;
        wrData = 8'h00;
        jump = 1'b0;
        disp = b2_r;
        case (kind)
            K_ALU: begin
                case (opc_r[7:4])
                    4'h0, 4'h1: begin
                        sum9 = {1'b0, aVal_r} + {1'b0, bVal} + {8'h00, cin};
                        nib5 = {1'b0, aVal_r[3:0]} + {1'b0, bVal[3:0]}
                             + {4'h0, cin};
                        res = sum9[7:0];
                        fl[`MCUDX_F_C] = sum9[8];
                        fl[`MCUDX_F_H] = nib5[4];
                        fl[`MCUDX_F_D] = 1'b0;
                        fl[`MCUDX_F_V] = (aVal_r[7] == bVal[7])
                                       && (res[7] != aVal_r[7]);
                        wrEn = 1'b1;
                    end
                    4'h5: begin
                        res = aVal_r & bVal;
                        fl[`MCUDX_F_V] = 1'b0;
                        wrEn = 1'b1;
                    end
                    default: begin
                        sum9 = {1'b0, aVal_r} - {1'b0, bVal};
                        res = sum9[7:0];
                        fl[`MCUDX_F_C] = sum9[8];
                        fl[`MCUDX_F_V] = (aVal_r[7] != bVal[7])
                                       && (res[7] != aVal_r[7]);
                    end
                endcase
                fl[`MCUDX_F_Z] = (res == 8'h00);
                fl[`MCUDX_F_S] = res[7];
            end
            K_DEC: begin
                res = aVal_r - 8'h01;
                fl[`MCUDX_F_Z] = (res == 8'h00);
                fl[`MCUDX_F_S] = res[7];
                fl[`MCUDX_F_V] = (aVal_r == 8'h80);
                wrEn = 1'b1;
            end
            K_COUNT_DOWN_WORD: begin
                res = w16[15:8];
                fl[`MCUDX_F_Z] = (w16 == 16'h0000);
                fl[`MCUDX_F_S] = w16[15];
                fl[`MCUDX_F_V] = ({aVal_r, ramRd} == 16'h8000);
                wrEn = 1'b1;
            end
            // bit ops, overflow left as is
            K_BIT: begin
                case (opc_r)
                    `MCUDX_OP_BAND: bitOp = aVal_r[0] & bVal[b1_r[3:1]];
                    `MCUDX_OP_BOR: bitOp = aVal_r[0] | bVal[b1_r[3:1]];
                    default: bitOp = aVal_r[0] ^ bVal[b1_r[3:1]];
                endcase
                fl[`MCUDX_F_Z] = ~bitOp;
                fl[`MCUDX_F_S] = 1'b0;
                wrEn = (opc_r != `MCUDX_OP_BCMP);
                res = {aVal_r[7:1], bitOp};
                if (b1_r[0]) begin
                    wrAddr = effB_c;
                    res = bVal;
                    res[b1_r[3:1]] = bitOp;
                end
            end
            K_CPIJ: begin
                jump = (aVal_r == ramRd) == (opc_r == `MCUDX_OP_COMPARE_STEP_JUMP_EQUAL);
                wrAddr = ptrAddr;
                res = ptrVal_r + 8'h01;
                wrEn = 1'b1;
            end
            K_LOOP_DOWN_BRANCH: begin
                res = aVal_r - 8'h01;
                jump = (res != 8'h00);
                disp = b1_r;
                wrEn = 1'b1;
            end
            default: res = 8'h00;
        endcase
        wrData = res;
    end

    assign coreWe = (state_r == ST_EXEC && wrEn) || (state_r == ST_WR2);

    mcudx_regfile #(.AW(8), .DW(8)) u_rf (
        .sys_clk(sys_clk),
        .we     (coreWe || (busWrite && busAddr[`MCUDX_RF_SEL] && halted)),
        .waddr  (coreWe ? (state_r == ST_WR2 ? (effA_r | 8'h01) : wrAddr)
                        : busAddr[7:0]),
        .wdata  (coreWe ? (state_r == ST_WR2 ? lo_r : wrData) : busWrData),
        .raddr  (ramRaddr),
        .rdata  (ramRd)
    );

    assign issue = (state_r == ST_FETCH)
                || (state_r == ST_OPC && prVal_r && opLen(progData) != 2'd0)
                || (state_r == ST_OPND && prVal_r && opndLeft_r != 2'd1);

    // sequencer
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= ST_HALT;
        end else begin
            case (state_r)
                ST_HALT: if (run_r) state_r <= ST_FETCH;
                ST_FETCH: state_r <= ST_OPC;
                ST_OPC: if (prVal_r) begin
                    if (opLen(progData) != 2'd0) state_r <= ST_OPND;
                    else state_r <= run_r ? ST_FETCH : ST_HALT;
                end
                ST_OPND: if (prVal_r && opndLeft_r == 2'd1) state_r <= ST_PTR;
                ST_PTR: state_r <= ST_RDA;
                ST_RDA: state_r <= ST_RDB;
                ST_RDB: state_r <= ST_EXEC;
                ST_EXEC: begin
                    if (kind == K_COUNT_DOWN_WORD) state_r <= ST_WR2;
                    else if (kind == K_CALL) state_r <= ST_CALL;
                    else state_r <= run_r ? ST_FETCH : ST_HALT;
                end
                ST_CALL: begin
                    if (opc_r == `MCUDX_OP_CALL_IA) state_r <= ST_VEC;
                    else state_r <= run_r ? ST_FETCH : ST_HALT;
                end
                ST_VEC: if (prVal_r && vecPh_r) begin
                    state_r <= run_r ? ST_FETCH : ST_HALT;
                end
                default: state_r <= run_r ? ST_FETCH : ST_HALT;
            endcase
        end
    end

    // program byte reads; data valid the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            progRead_r <= 1'b0;
            progAddr_r <= 16'h0000;
            prVal_r <= 1'b0;
            vecPh_r <= 1'b0;
        end else begin
            prVal_r <= progRead_r;
            progRead_r <= 1'b0;
            if (issue) begin
                progRead_r <= 1'b1;
                progAddr_r <= pc_r;
            end else if (state_r == ST_CALL
                         && opc_r == `MCUDX_OP_CALL_IA) begin
                progRead_r <= 1'b1;
                progAddr_r <= {8'h00, b1_r};
                vecPh_r <= 1'b0;
            end else if (state_r == ST_VEC && prVal_r && !vecPh_r) begin
                progRead_r <= 1'b1;
                progAddr_r <= {8'h00, b1_r + 8'h01};
                vecPh_r <= 1'b1;
            end
        end
    end

    // opcode and operand capture
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            opc_r <= 8'hFF;
            b1_r <= 8'h00;
            b2_r <= 8'h00;
            opndLeft_r <= 2'd0;
        end else if (state_r == ST_OPC && prVal_r) begin
            opc_r <= progData;
            opndLeft_r <= opLen(progData);
        end else if (state_r == ST_OPND && prVal_r) begin
            if (opndLeft_r == opLen(opc_r)) b1_r <= progData;
            else b2_r <= progData;
            opndLeft_r <= opndLeft_r - 2'd1;
        end
    end

    // operand values and call target
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ptrVal_r <= 8'h00;
            effA_r <= 8'h00;
            aVal_r <= 8'h00;
            lo_r <= 8'h00;
            callT_r <= 16'h0000;
        end else begin
            if (state_r == ST_RDA) begin
                ptrVal_r <= ramRd;
                effA_r <= effA_c;
            end
            if (state_r == ST_RDB) aVal_r <= ramRd;
            if (state_r == ST_EXEC) begin
                lo_r <= w16[7:0];
                // direct target is a full 16-bit address
                callT_r <= (opc_r == `MCUDX_OP_CALL_DA) ? {b1_r, b2_r}
                                                        : {aVal_r, ramRd};
            end
        end
    end

    // program counter
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pc_r <= `MCUDX_RST_PC;
        end else if (halted && busWrite && busAddr == `MCUDX_A_PCH) begin
            pc_r[15:8] <= busWrData;
        end else if (halted && busWrite && busAddr == `MCUDX_A_PCL) begin
            pc_r[7:0] <= busWrData;
        end else if (issue) begin
            pc_r <= pc_r + 16'h0001;
        end else if (state_r == ST_EXEC && jump) begin
            pc_r <= pc_r + {{8{disp[7]}}, disp};
        end else if (state_r == ST_CALL && opc_r != `MCUDX_OP_CALL_IA) begin
            pc_r <= callT_r;
        end else if (state_r == ST_VEC && prVal_r) begin
            if (vecPh_r) pc_r[7:0] <= progData;
            else pc_r[15:8] <= progData;
        end
    end

    // stack: SP minus two, PC high then low
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sp_r <= `MCUDX_RST_SP;
            stkWr_r <= '0;
        end else begin
            stkWr_r <= '0;
            if (halted && busWrite && busAddr == `MCUDX_A_SPH) begin
                sp_r[15:8] <= busWrData;
            end else if (halted && busWrite && busAddr == `MCUDX_A_SPL) begin
                sp_r[7:0] <= busWrData;
            end else if (state_r == ST_EXEC && kind == K_CALL) begin
                sp_r <= sp_r - 16'h0002;
                stkWr_r <= '{we: 1'b1, addr: sp_r - 16'h0002,
                             data: pc_r[15:8]};
            end else if (state_r == ST_CALL) begin
                stkWr_r <= '{we: 1'b1, addr: sp_r + 16'h0001, data: pc_r[7:0]};
            end
        end
    end

    // flags change through the execute result, a halted bus write, or the carry flip opcode
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            flags_r <= `MCUDX_RST_FLAGS;
        end else if (halted && busWrite && busAddr == `MCUDX_A_FLAGS) begin
            flags_r <= busWrData;
        end else if (state_r == ST_OPC && prVal_r
                     && progData == `MCUDX_OP_CFLIP) begin
            flags_r[`MCUDX_F_C] <= ~flags_r[`MCUDX_F_C];
        end else if (state_r == ST_EXEC) begin
            flags_r <= fl;
        end
    end

    // control: run, pointers, interrupt enable
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            run_r <= 1'b0;
            irqEn_r <= 1'b0;
            rp0_r <= `MCUDX_RST_RP0;
            rp1_r <= `MCUDX_RST_RP1;
        end else begin
            if (busWrite && busAddr == `MCUDX_A_CTRL)
                run_r <= busWrData[`MCUDX_CTRL_RUN];
            if (halted && busWrite && busAddr == `MCUDX_A_RP0)
                rp0_r <= busWrData;
            if (halted && busWrite && busAddr == `MCUDX_A_RP1)
                rp1_r <= busWrData;
            if (state_r == ST_OPC && prVal_r) begin
                if (progData == `MCUDX_OP_IRQOFF) irqEn_r <= 1'b0;
                if (progData == `MCUDX_OP_IRQON) irqEn_r <= 1'b1;
            end
        end
    end

    // bus reads; register file contents are seen via the write-back port
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            busRdData_r <= 8'h00;
            regWb_r <= '0;
        end else begin
            regWb_r <= '{valid: coreWe,
                         addr: (state_r == ST_WR2) ? (effA_r | 8'h01) : wrAddr,
                         data: (state_r == ST_WR2) ? lo_r : wrData};
            busRdData_r <= 8'h00;
            if (busRead) begin
                case (busAddr)
                    `MCUDX_A_CTRL: busRdData_r <= {7'h00, run_r};
                    `MCUDX_A_FLAGS: busRdData_r <= flags_r;
                    `MCUDX_A_RP0: busRdData_r <= rp0_r;
                    `MCUDX_A_RP1: busRdData_r <= rp1_r;
                    `MCUDX_A_SPH: busRdData_r <= sp_r[15:8];
                    `MCUDX_A_SPL: busRdData_r <= sp_r[7:0];
                    `MCUDX_A_PCH: busRdData_r <= pc_r[15:8];
                    `MCUDX_A_PCL: busRdData_r <= pc_r[7:0];
                    `MCUDX_A_STAT: busRdData_r <= {irqEn_r, 6'h00, halted};
                    default: busRdData_r <= 8'h00;
                endcase
            end
        end
    end
endmodule

// ===== src/mcudx_defs.svh
// constants for the operand decode and execute core
`ifndef MCUDX_DEFS_SVH
`define MCUDX_DEFS_SVH

// register bus offsets (bit 8 of the address selects the register file)
`define MCUDX_A_CTRL   9'h000
`define MCUDX_A_FLAGS  9'h001
`define MCUDX_A_RP0    9'h002
`define MCUDX_A_RP1    9'h003
`define MCUDX_A_SPH    9'h004
`define MCUDX_A_SPL    9'h005
`define MCUDX_A_PCH    9'h006
`define MCUDX_A_PCL    9'h007
`define MCUDX_A_STAT   9'h008
`define MCUDX_RF_SEL   8
`define MCUDX_CTRL_RUN 0

// flag bit positions
`define MCUDX_F_C 7
`define MCUDX_F_Z 6
`define MCUDX_F_S 5
`define MCUDX_F_V 4
`define MCUDX_F_D 3
`define MCUDX_F_H 2

// reset values
`define MCUDX_RST_FLAGS 8'h00
`define MCUDX_RST_RP0   8'hC0
`define MCUDX_RST_RP1   8'hC8
`define MCUDX_RST_SP    16'h0000
`define MCUDX_RST_PC    16'h0000

// opcodes handled one by one
`define MCUDX_OP_DEC_R   8'h00
`define MCUDX_OP_DEC_IR  8'h01
`define MCUDX_OP_COUNT_DOWN_WORD_RR 8'h80
`define MCUDX_OP_COUNT_DOWN_WORD_IR 8'h81
`define MCUDX_OP_BAND    8'h67
`define MCUDX_OP_BOR     8'h07
`define MCUDX_OP_BIT_XOR_OP    8'h27
`define MCUDX_OP_BCMP    8'h17
`define MCUDX_OP_COMPARE_STEP_JUMP_EQUAL   8'hC2
`define MCUDX_OP_COMPARE_STEP_JUMP_UNEQUAL  8'hD2
`define MCUDX_OP_CALL_DA 8'hF6
`define MCUDX_OP_CALL_RR 8'hF4
`define MCUDX_OP_CALL_IA 8'hD4
`define MCUDX_OP_CFLIP   8'hEF
`define MCUDX_OP_IRQOFF  8'h8F
`define MCUDX_OP_IRQON   8'h9F
`define MCUDX_NIB_LOOP_DOWN_BRANCH   4'hA

`endif

// ===== src/mcudx_pkg.sv
// types shared by the operand decode and execute core
package mcudx_pkg;

    typedef enum logic [10:0] {
        ST_HALT = 11'h001,
        ST_FETCH = 11'h002,
        ST_OPC = 11'h004,
        ST_OPND = 11'h008,
        ST_PTR = 11'h010,
        ST_RDA = 11'h020,
        ST_RDB = 11'h040,
        ST_EXEC = 11'h080,
        ST_WR2 = 11'h100,
        ST_CALL = 11'h200,
        ST_VEC = 11'h400
    } mcudx_state_t;

    typedef enum logic [2:0] {
        K_NONE, K_ALU, K_DEC, K_COUNT_DOWN_WORD, K_BIT, K_CPIJ, K_LOOP_DOWN_BRANCH, K_CALL
    } mcudx_kind_t;

    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  data;
    } mcudx_stk_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } mcudx_wb_t;

endpackage

// ===== src/mcudx_regfile.sv
// register file memory with registered read data
`timescale 1ns/1ps
module mcudx_regfile #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input  wire logic          sys_clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // no reset: contents are undefined until written
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        rdata <= mem[raddr];
    end
endmodule

// ===== tb/mcudx_prog_mem.sv
// program memory model answering each fetch one cycle later
`timescale 1ns/1ps
module mcudx_prog_mem (
    input  logic        sys_clk,
    input  logic [15:0] progAddr_r,
    input  logic        progRead_r,
    output logic [7:0]  progData
);
    logic [7:0] mem [0:65535];
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        progData = 8'h00;
    end
    // stale byte is inverted so a late sample cannot match by luck
    always @(posedge sys_clk) begin
        progData <= (progRead_r === 1'b1) ? mem[progAddr_r] : ~progData;
    end
endmodule

// ===== tb/mcudx_core_monitor.sv
// port checker for the decode and execute core
`timescale 1ns/1ps
module mcudx_core_monitor
    import mcudx_pkg::*;
(
    input logic       sys_clk,
    input logic       reset,
    input logic [8:0] busAddr,
    input logic       busRead,
    input logic [7:0] busRdData_r,
    input logic       progRead_r,
    input mcudx_stk_t stkWr_r,
    input mcudx_wb_t  regWb_r
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_rd_idle: assert property (!$past(busRead) |-> busRdData_r == 8'h00)
        else $error("read data outside answer cycle");
    a_rf_read: assert property ($past(busRead) && $past(busAddr[8])
        |-> busRdData_r == 8'h00) else $error("register file read not 0");
    a_stat_resv: assert property ($past(busRead) && $past(busAddr) == 9'h008
        |-> busRdData_r[6:1] == 6'h00) else $error("status spare bits set");
    a_reset_quiet: assert property ($past(reset)
        |-> !progRead_r && !stkWr_r.we && !regWb_r.valid)
        else $error("activity right after reset");
    a_fetch_gap: assert property (progRead_r |=> !progRead_r)
        else $error("fetches too close");
    a_push_pair: assert property ($rose(stkWr_r.we) |=> stkWr_r.we
        && stkWr_r.addr == $past(stkWr_r.addr) + 16'h0001)
        else $error("push pair broken");
    a_push_two: assert property (stkWr_r.we && $past(stkWr_r.we)
        |=> !stkWr_r.we) else $error("more than two push bytes");
    a_pair_even: assert property (regWb_r.valid && $past(regWb_r.valid)
        |-> !$past(regWb_r.addr[0])
        && regWb_r.addr == $past(regWb_r.addr) + 8'h01)
        else $error("word write not on even pair");
endmodule
bind mcudx_core mcudx_core_monitor u_mcudx_core_monitor (
    .sys_clk(sys_clk), .reset(reset), .busAddr(busAddr), .busRead(busRead),
    .busRdData_r(busRdData_r), .progRead_r(progRead_r),
    .stkWr_r(stkWr_r), .regWb_r(regWb_r));

// ===== tb/tb.sv
// random and corner tests of the decode and execute core
`timescale 1ns/1ps
module tb;
    import mcudx_pkg::*;
    logic        sys_clk = 1'h0;
    logic        reset = 1'h1;
    logic        busWrite = 1'h0;
    logic        busRead = 1'h0;
    logic        progRead_r;
    logic [8:0]  busAddr = 9'h000;
    logic [7:0]  busWrData = 8'h00;
    logic [7:0]  busRdData_r, progData, rd, a, b, f, op;
    logic [7:0]  wbA[4], wbD[4], skD[2];
    logic [7:0]  ops[5] = '{8'h04, 8'h54, 8'hA4, 8'h00, 8'h80};
    logic [15:0] progAddr_r, pc, sp, skA[2];
    logic [23:0] x;
    mcudx_stk_t  stkWr_r;
    mcudx_wb_t   regWb_r;
    int          err_count = 0, check_count = 0, wbN = 0, skN = 0;
    always #5 sys_clk = ~sys_clk;
    mcudx_core u_mcudx_core (.sys_clk(sys_clk), .reset(reset),
        .busAddr(busAddr), .busWrData(busWrData), .busWrite(busWrite),
        .busRead(busRead), .busRdData_r(busRdData_r),
        .progAddr_r(progAddr_r), .progRead_r(progRead_r),
        .progData(progData), .stkWr_r(stkWr_r), .regWb_r(regWb_r));
    mcudx_prog_mem u_mcudx_prog_mem (.sys_clk(sys_clk),
        .progAddr_r(progAddr_r), .progRead_r(progRead_r),
        .progData(progData));
    always @(posedge sys_clk) begin
        if (regWb_r.valid && wbN < 4) begin
            wbA[wbN] = regWb_r.addr;
            wbD[wbN] = regWb_r.data;
            wbN++;
        end
        if (stkWr_r.we && skN < 2) begin
            skA[skN] = stkWr_r.addr;
            skD[skN] = stkWr_r.data;
            skN++;
        end
    end
    function automatic logic [23:0] model(logic [7:0] o, p, q, e);
        logic [16:0] s;
        case (o)
            8'h04: s = p + q;
            8'h54: s = p & q;
            8'hA4: s = p - q;
            8'h00: s = p - 17'h1;
            default: s = {p, q} - 17'h1;
        endcase
        if (o == 8'h04 || o == 8'hA4) e[7] = s[8];
        if (o == 8'h04) begin
            e[3] = 1'h0;
            e[2] = p[3:0] + q[3:0] > 5'h0F;
            e[4] = p[7] == q[7] && s[7] != p[7];
        end
        if (o == 8'hA4) e[4] = p[7] != q[7] && s[7] != p[7];
        if (o == 8'h54) e[4] = 1'h0;
        if (o == 8'h00) e[4] = p == 8'h80;
        if (o == 8'h80) begin
            e[4] = {p, q} == 16'h8000;
            e[6] = s[15:0] == 16'h0000;
            e[5] = s[15];
        end else begin
            e[6] = s[7:0] == 8'h00;
            e[5] = s[7];
        end
        return {s[15:0], e};
    endfunction
    task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [8:0] ad, logic [7:0] d);
        @(posedge sys_clk);
        busAddr <= ad;
        busWrData <= d;
        busWrite <= 1'h1;
        @(posedge sys_clk);
        busWrite <= 1'h0;
    endtask
    task automatic rdb(logic [8:0] ad);
        @(posedge sys_clk);
        busAddr <= ad;
        busRead <= 1'h1;
        @(posedge sys_clk);
        busRead <= 1'h0;
        @(posedge sys_clk);
        rd = busRdData_r;
    endtask
    // run one instruction: clearing run early stops after it completes
    task automatic run(logic [15:0] at);
        wr(9'h006, at[15:8]);
        wr(9'h007, at[7:0]);
        wbN = 0;
        skN = 0;
        wr(9'h000, 8'h01);
        repeat (3) @(posedge sys_clk);
        wr(9'h000, 8'h00);
        for (int n = 0; n < 60; n++) begin
            rdb(9'h008);
            if (rd[0] === 1'h1) break;
        end
        if (rd[0] !== 1'h1) begin
            err_count++;
            end_sim();
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(27872));
        repeat (20) @(posedge sys_clk);
        reset <= 1'h0;
        rdb(9'h0FF);
        chk("unmapped", {16'h0, rd}, 24'h0);
        rdb(9'h110);
        chk("rf read", {16'h0, rd}, 24'h0);
        for (int i = 0; i < 20; i++) begin
            op = ops[i % 5];
            a = (i < 5) ? 8'h80 : 8'($urandom);
            b = (i < 5) ? 8'h80 : 8'($urandom);
            f = 8'($urandom);
            pc = 16'($urandom);
            wr(9'h110, a);
            wr(9'h111, b);
            wr(9'h001, f);
            u_mcudx_prog_mem.mem[pc] = op;
            u_mcudx_prog_mem.mem[pc + 16'h1] = op[3:0] == 4'h0 ? 8'h10 : 8'h11;
            u_mcudx_prog_mem.mem[pc + 16'h2] = op[3:0] == 4'h0 ? 8'hFF : 8'h10;
            run(pc);
            x = model(op, a, b, f);
            rdb(9'h001);
            chk("flags", {16'h0, rd & 8'hFC}, {16'h0, x[7:0] & 8'hFC});
            chk("writes", 24'(wbN), op == 8'hA4 ? 24'h0 : op == 8'h80 ? 24'h2 : 24'h1);
            if (wbN > 0) chk("wb0", {8'h0, wbA[0], wbD[0]}, {8'h0, 8'h10, op == 8'h80 ? x[23:16] : x[15:8]});
            if (op == 8'h80) chk("wb1", {8'h0, wbA[1], wbD[1]}, {8'h0, 8'h11, x[15:8]});
            $display("test alu %0d done", i);
        end
        for (int i = 0; i < 3; i++) begin
            pc = 16'($urandom);
            sp = 16'($urandom);
            x = 24'($urandom);
            wr(9'h004, sp[15:8]);
            wr(9'h005, sp[7:0]);
            u_mcudx_prog_mem.mem[pc] = 8'hF6;
            u_mcudx_prog_mem.mem[pc + 16'h1] = x[15:8];
            u_mcudx_prog_mem.mem[pc + 16'h2] = x[7:0];
            run(pc);
            pc = pc + 16'h3;
            chk("push0", {skA[0], skD[0]}, {sp - 16'h2, pc[15:8]});
            chk("push1", {skA[1], skD[1]}, {sp - 16'h1, pc[7:0]});
            rdb(9'h006);
            a = rd;
            rdb(9'h007);
            chk("target", {8'h0, a, rd}, {8'h0, x[15:0]});
            $display("test call %0d done", i);
        end
        end_sim();
    end
endmodule
